// file: rtl/adcsq_pkg.sv
package adcsq_pkg;
   // register byte addresses
   localparam logic [7:0] ADCSQ_CTRL_OFF = 8'h00;
   localparam logic [7:0] ADCSQ_DAC_RESULT_REGISTER_ZERO_OFF = 8'h04;
   localparam logic [7:0] ADCSQ_DAC_REGISTER_ONE_OFF = 8'h08;
   localparam logic [7:0] ADCSQ_PWR_OFF = 8'h0c;
   localparam logic [7:0] ADCSQ_SAMP_OFF = 8'h10;
   // control register fields
   localparam int ADCSQ_CH_LSB = 0;
   localparam int ADCSQ_RCSEL_BIT = 2;
   localparam int ADCSQ_START_BIT = 3;
   localparam int ADCSQ_DONE_BIT = 4;
   localparam int ADCSQ_DACEN0_BIT = 5;
   localparam int ADCSQ_ENADC_BIT = 6;
   localparam int ADCSQ_DACEN1_BIT = 7;
   // power control fields
   localparam int ADCSQ_IDLE_BIT = 0;
   localparam int ADCSQ_PDOWN_BIT = 1;
   localparam int ADCSQ_IEN_BIT = 2;
   // reset values
   localparam logic [7:0] ADCSQ_CTRL_RST = 8'h00;
   localparam logic [7:0] ADCSQ_DAC_RST = 8'h00;
   localparam logic [7:0] ADCSQ_PWR_RST = 8'h00;
   // timing
   localparam int ADCSQ_PCLK_PER_MC = 6;
   localparam int ADCSQ_CPU_MC = 31;
   localparam int ADCSQ_CPU_CYC = ADCSQ_CPU_MC * ADCSQ_PCLK_PER_MC;
   localparam int ADCSQ_SYNC_MC = 3;
   localparam int ADCSQ_SYNC_CYC = ADCSQ_SYNC_MC * ADCSQ_PCLK_PER_MC;
   localparam int ADCSQ_RC_CLKS = 108;
   localparam int ADCSQ_BITS = 8;
   typedef enum logic [1:0] {adcsq_idle, adcsq_sync, adcsq_conv} adcsq_state_t;
endpackage : adcsq_pkg

// file: rtl/adcsq_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_sync2 (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // level in and out
   input wire logic d,
   output logic q
);
   logic s1_r;
   logic s2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule : adcsq_sync2
`default_nettype wire

// file: rtl/adcsq_top.sv
// How it works
// - completion ends idle when interrupt enabled
// - rc clock keeps converting in power-down
// - cpu clock power-down aborts, no wake
// - two dac channels driven by registers
// - output is (value+0.5)*span/256
// - cpu clock conversion is 31 machine cycles
// - rc path adds sync plus rc clocks
// - rc select switches converter to rc
`timescale 1ns/1ps
`default_nettype none
module adcsq_top (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog side
   input wire logic rc_clk_tick,
   input wire logic comp_in,
   output logic [3:0] analog_mux_sel,
   output logic [7:0] dac_result_register_zero_level,
   output logic [7:0] dac_register_one_level,
   output logic dac_result_register_zero_on,
   output logic dac_register_one_on,
   output logic adc_on,
   // cpu power
   output logic cpu_idle,
   output logic cpu_pdown,
   output logic wake_cpu,
   output logic conv_irq
);
   import adcsq_pkg::*;

   logic [7:0] ctrl_r;
   logic [7:0] dac_result_register_zero_r;
   logic [7:0] dac_register_one_r;
   logic [7:0] pwr_r;
   logic [7:0] cnt_r;
   logic [7:0] sar_r;
   logic [7:0] mask_r;
   logic wake_r;
   adcsq_state_t st_r;
   logic rc_tick_s;
   logic comp_s;
   logic rc_tick_d_r;

   adcsq_sync2 u_rc (.pclk(pclk), .presetn(presetn), .d(rc_clk_tick), .q(rc_tick_s));
   adcsq_sync2 u_cmp (.pclk(pclk), .presetn(presetn), .d(comp_in), .q(comp_s));

   wire wr = psel & penable & pwrite;
   wire rd_hit_ctrl = paddr == ADCSQ_CTRL_OFF;
   wire hit_dac_result_register_zero = paddr == ADCSQ_DAC_RESULT_REGISTER_ZERO_OFF;
   wire hit_dac_register_one = paddr == ADCSQ_DAC_REGISTER_ONE_OFF;
   wire hit_pwr = paddr == ADCSQ_PWR_OFF;
   wire hit_samp = paddr == ADCSQ_SAMP_OFF;
   wire mapped = rd_hit_ctrl | hit_dac_result_register_zero | hit_dac_register_one | hit_pwr | hit_samp;
   wire wr_ctrl = wr & rd_hit_ctrl;
   wire busy = ctrl_r[ADCSQ_START_BIT];
   wire done = ctrl_r[ADCSQ_DONE_BIT];
   wire idle_flags = ~busy & ~done;
   wire rcsel = ctrl_r[ADCSQ_RCSEL_BIT];
   wire pdown = pwr_r[ADCSQ_PDOWN_BIT];
   wire rc_edge = rc_tick_s & ~rc_tick_d_r;
   // converter step: cpu clock every cycle, rc clock on rc edges
   wire step = rcsel ? rc_edge : 1'b1;
   wire abort = pdown & ~rcsel & (st_r != adcsq_idle);
   wire start_req = wr_ctrl & pwdata[ADCSQ_START_BIT] & idle_flags;
   wire [7:0] conv_len = rcsel ? 8'(ADCSQ_RC_CLKS) : 8'(ADCSQ_CPU_CYC);
   wire finish = (st_r == adcsq_conv) & step & (cnt_r == 8'h01) & ~abort;
   // sar sample points spread across the conversion
   wire sar_step = (st_r == adcsq_conv) & step & (mask_r != 8'h00) & ~abort &
      (cnt_r[3:0] == 4'h1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_tick_d_r <= 1'b0;
      end else begin
         rc_tick_d_r <= rc_tick_s;
      end
   end

   // control register: hardware set of done beats software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= ADCSQ_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            if (idle_flags) begin
               ctrl_r[1:0] <= pwdata[1:0];
               ctrl_r[ADCSQ_RCSEL_BIT] <= pwdata[ADCSQ_RCSEL_BIT];
               ctrl_r[ADCSQ_DACEN0_BIT] <= pwdata[ADCSQ_DACEN0_BIT];
            end
            ctrl_r[ADCSQ_ENADC_BIT] <= pwdata[ADCSQ_ENADC_BIT];
            ctrl_r[ADCSQ_DACEN1_BIT] <= pwdata[ADCSQ_DACEN1_BIT];
            if (!pwdata[ADCSQ_DONE_BIT]) begin
               ctrl_r[ADCSQ_DONE_BIT] <= 1'b0;
            end
            if (start_req) begin
               ctrl_r[ADCSQ_START_BIT] <= 1'b1;
            end
         end
         if (finish) begin
            ctrl_r[ADCSQ_START_BIT] <= 1'b0;
            ctrl_r[ADCSQ_DONE_BIT] <= 1'b1;
         end
         if (abort) begin
            ctrl_r[ADCSQ_START_BIT] <= 1'b0;
         end
      end
   end

   // sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= adcsq_idle;
         cnt_r <= 8'h00;
      end else if (abort) begin
         st_r <= adcsq_idle;
         cnt_r <= 8'h00;
      end else begin
         unique case (st_r)
            adcsq_idle: begin
               if (start_req) begin
                  st_r <= rcsel ? adcsq_sync : adcsq_conv;
                  cnt_r <= rcsel ? 8'(ADCSQ_SYNC_CYC) : conv_len;
               end
            end
            adcsq_sync: begin
               if (cnt_r == 8'h01) begin
                  st_r <= adcsq_conv;
                  cnt_r <= conv_len;
               end else begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            adcsq_conv: begin
               if (finish) begin
                  st_r <= adcsq_idle;
               end else if (step) begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
         endcase
      end
   end

   // successive approximation into the shared result register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sar_r <= 8'h00;
         mask_r <= 8'h00;
      end else if (start_req) begin
         sar_r <= 8'h80;
         mask_r <= 8'h80;
      end else if (sar_step) begin
         sar_r <= (comp_s ? sar_r : (sar_r & ~mask_r)) | (mask_r >> 1);
         mask_r <= mask_r >> 1;
      end
   end

   // dac registers; result of a conversion lands in dac zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_result_register_zero_r <= ADCSQ_DAC_RST;
         dac_register_one_r <= ADCSQ_DAC_RST;
      end else begin
         if (finish || abort) begin
            dac_result_register_zero_r <= sar_r;
         end else if (wr && hit_dac_result_register_zero) begin
            dac_result_register_zero_r <= pwdata[7:0];
         end
         if (wr && hit_dac_register_one) begin
            dac_register_one_r <= pwdata[7:0];
         end
      end
   end

   // power control; completion wakes from idle when interrupt enabled, abort does not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_r <= ADCSQ_PWR_RST;
         wake_r <= 1'b0;
      end else begin
         wake_r <= finish & pwr_r[ADCSQ_IEN_BIT] & (pwr_r[ADCSQ_IDLE_BIT] | pdown);
         if (wr && hit_pwr) begin
            pwr_r <= {5'h00, pwdata[2:0]};
         end else if (finish && pwr_r[ADCSQ_IEN_BIT]) begin
            pwr_r[ADCSQ_IDLE_BIT] <= 1'b0;
            pwr_r[ADCSQ_PDOWN_BIT] <= 1'b0;
         end
      end
   end

   assign prdata = !psel ? 32'h0000_0000 :
      rd_hit_ctrl ? {24'h000000, ctrl_r} :
      hit_dac_result_register_zero ? {24'h000000, dac_result_register_zero_r} :
      hit_dac_register_one ? {24'h000000, dac_register_one_r} :
      hit_pwr ? {24'h000000, pwr_r} :
      hit_samp ? {24'h000000, sar_r} : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   assign analog_mux_sel = 4'(1) << ctrl_r[1:0];
   // dac output (value+0.5)*span/256 is the ladder tap selected by the code
   assign dac_result_register_zero_level = dac_result_register_zero_r;
   assign dac_register_one_level = dac_register_one_r;
   assign dac_result_register_zero_on = ctrl_r[ADCSQ_DACEN0_BIT];
   assign dac_register_one_on = ctrl_r[ADCSQ_DACEN1_BIT];
   assign adc_on = ctrl_r[ADCSQ_ENADC_BIT];
   assign cpu_idle = pwr_r[ADCSQ_IDLE_BIT];
   assign cpu_pdown = pwr_r[ADCSQ_PDOWN_BIT];
   assign wake_cpu = wake_r;
   assign conv_irq = done & pwr_r[ADCSQ_IEN_BIT];
endmodule : adcsq_top
`default_nettype wire

// file: tb/adcsq_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_assertions (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // converter side
   input wire logic [3:0] analog_mux_sel,
   input wire logic [7:0] dac_register_one_level,
   input wire logic cpu_idle,
   input wire logic cpu_pdown,
   input wire logic wake_cpu,
   input wire logic conv_irq
);
   import adcsq_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr = psel && penable && pwrite;
   wire acc = psel && penable;
   wire hit = paddr inside {ADCSQ_CTRL_OFF, ADCSQ_DAC_RESULT_REGISTER_ZERO_OFF, ADCSQ_DAC_REGISTER_ONE_OFF, ADCSQ_PWR_OFF, ADCSQ_SAMP_OFF};
   sequence s_done;
      $rose(conv_irq) && $past(cpu_idle) && !$past(psel);
   endsequence
   sequence s_wake;
      !cpu_idle && wake_cpu;
   endsequence
   a_mux_onehot: assert property ($onehot(analog_mux_sel))
      else $error("channel select not one-hot");
   a_dac_register_one_write: assert property (wr && paddr == ADCSQ_DAC_REGISTER_ONE_OFF |=> dac_register_one_level == $past(pwdata[7:0]))
      else $error("dac one level not updated");
   a_pwr_write: assert property (wr && paddr == ADCSQ_PWR_OFF |=> {cpu_pdown, cpu_idle} == $past(pwdata[1:0]))
      else $error("power bits wrong");
   a_wake_pulse: assert property (wake_cpu |=> !wake_cpu)
      else $error("wake longer than one cycle");
   a_wake_cause: assert property (wake_cpu |-> conv_irq && !cpu_idle && !cpu_pdown)
      else $error("wake without completion");
   a_idle_exit: assert property (s_done |-> s_wake)
      else $error("idle not ended on completion");
   a_bad_addr: assert property (acc && !hit |-> pslverr)
      else $error("unmapped access not flagged");
   a_good_addr: assert property (acc && hit |-> !pslverr)
      else $error("mapped access flagged");
   a_rdata_idle: assert property (!psel |-> prdata == 32'h0)
      else $error("read data not zero when idle");
endmodule : adcsq_top_assertions
bind adcsq_top adcsq_top_assertions u_chk (.*);
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import adcsq_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e; logic err;} adcsq_row_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rc_clk_tick = 0, comp_in = 1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, dac_result_register_zero_on, dac_register_one_on, adc_on, cpu_idle, cpu_pdown, wake_cpu, conv_irq, woke, er;
   logic [3:0] analog_mux_sel;
   logic [7:0] dac_result_register_zero_level, dac_register_one_level;
   int miscompares = 0, compares = 0, cyc = 0, t0, tk, d;
   adcsq_row_t rows[5] = '{'{ADCSQ_DAC_RESULT_REGISTER_ZERO_OFF, 8'ha5, 8'ha5, 1'b0}, '{ADCSQ_DAC_REGISTER_ONE_OFF, 8'h3c, 8'h3c, 1'b0},
      '{ADCSQ_PWR_OFF, 8'h04, 8'h04, 1'b0}, '{ADCSQ_CTRL_OFF, 8'h41, 8'h41, 1'b0}, '{8'h14, 8'h11, 8'h00, 1'b1}};
   adcsq_top uut (.*);
   initial forever #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (wake_cpu) woke <= 1'b1;
      if (cyc % 3 == 2) rc_clk_tick <= ~rc_clk_tick;
      if (cyc > 20000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, v};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      tk = cyc;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_irq;
      do @(posedge pclk); while (conv_irq !== 1'b1 && cyc - t0 < 2000);
      d = cyc - t0;
   endtask : wait_irq
   task automatic summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      woke <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, ADCSQ_CTRL_OFF, 8'h00);
      chk("ctrl reset", 32'h0, rd);
      chk("mux reset", 4'b0001, analog_mux_sel);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(1, rows[i].a, rows[i].w);
         apb(0, rows[i].a, 8'h00);
         chk("row read", rows[i].e, rd);
         chk("row err", rows[i].err, er);
      end
      chk("mux", 4'b0010, analog_mux_sel);
      chk("dac_register_one", 8'h3c, dac_register_one_level);
      chk("adc on", 1, adc_on);
      chk("dac en", 0, {dac_register_one_on, dac_result_register_zero_on});
      $display("test rows done");
      woke <= 1'b0;
      apb(1, ADCSQ_CTRL_OFF, 8'h49);
      t0 = tk;
      apb(1, ADCSQ_PWR_OFF, 8'h05);
      apb(1, ADCSQ_CTRL_OFF, 8'h4a);
      chk("busy mux", 4'b0010, analog_mux_sel);
      wait_irq();
      chk("cpu time", ADCSQ_CPU_CYC + 1, d);
      repeat (2) @(posedge pclk);
      chk("woke", 1, woke);
      chk("idle", 0, cpu_idle);
      apb(0, ADCSQ_CTRL_OFF, 8'h00);
      chk("ctrl done", 8'h51, rd);
      apb(0, ADCSQ_DAC_RESULT_REGISTER_ZERO_OFF, 8'h00);
      chk("result", 8'hff, rd);
      chk("dac_result_register_zero level", 8'hff, dac_result_register_zero_level);
      apb(1, ADCSQ_CTRL_OFF, 8'h5b);
      apb(0, ADCSQ_CTRL_OFF, 8'h00);
      chk("restart", 8'h51, rd);
      repeat (2) apb(1, ADCSQ_CTRL_OFF, 8'h40);
      apb(0, ADCSQ_CTRL_OFF, 8'h00);
      chk("cleared", 8'h40, rd);
      $display("test cpu clock done");
      apb(1, ADCSQ_CTRL_OFF, 8'h44);
      woke <= 1'b0;
      apb(1, ADCSQ_CTRL_OFF, 8'h4c);
      t0 = tk;
      apb(1, ADCSQ_PWR_OFF, 8'h06);
      wait_irq();
      d = d - (ADCSQ_SYNC_CYC + ADCSQ_RC_CLKS * ADCSQ_PCLK_PER_MC);
      chk("rc time", 1, d >= -6 && d <= 31);
      repeat (2) @(posedge pclk);
      chk("rc woke", 1, woke);
      apb(0, ADCSQ_CTRL_OFF, 8'h00);
      chk("rc ctrl", 8'h54, rd);
      repeat (2) apb(1, ADCSQ_CTRL_OFF, 8'h40);
      $display("test rc clock done");
      woke <= 1'b0;
      apb(1, ADCSQ_CTRL_OFF, 8'h48);
      apb(1, ADCSQ_PWR_OFF, 8'h06);
      repeat (300) @(posedge pclk);
      chk("abort irq", 0, conv_irq);
      chk("abort wake", 0, woke);
      chk("abort pdown", 1, cpu_pdown);
      apb(0, ADCSQ_CTRL_OFF, 8'h00);
      chk("abort ctrl", 8'h40, rd);
      $display("test abort done");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
